// file: src/serial_flags_params.svh
// Offsets, field positions, reset values and bit-timing counts of the serial status block.
// Holds definitions only; included by both module files of the block.
`ifndef SERIAL_FLAGS_PARAMS_SVH
`define SERIAL_FLAGS_PARAMS_SVH
`define OFF_STATUS 4'h0
`define OFF_DATA 4'h4
`define OFF_CTRL 4'h8
`define ST_TX_BUFFER_EMPTY_FLAG 7
`define ST_TC 6
`define ST_RX_BUFFER_FULL_FLAG 5
`define ST_IDLE 4
`define ST_OR 3
`define ST_NF 2
`define ST_FE 1
`define ST_PF 0
`define STATUS_RST 8'hc0
`define RX_FLAG_MASK 8'h3f
`define CT_PT 0
`define CT_PE 1
`define CT_ILT 2
`define CT_M9 3
`define CT_SBK 4
`define CT_TE 5
`define CT_TIE 7
`define CTRL_RST 8'h00
`define CTRL_MASK 8'hbf
`define LAST_TICK 4'hf
`define START_WIN_LO 4'h3
`define BIT_WIN_LO 4'h7
`define BIT_DECIDE 4'h9
`define START_MAJ 3'h4
`define BIT_MAJ 3'h2
`define BIT_ALL 3'h3
`define DATA_LAST_8 4'h7
`define DATA_LAST_9 4'h8
`define IDLE_BITS_8 4'ha
`define IDLE_BITS_9 4'hb
`define TX_BITS_8 4'ha
`define TX_BITS_9 4'hb
`endif

// file: src/serial_flags_pkg.sv
// Types shared by the serial status block and its transmit shifter.
// Compiled before any module that names them.
package serial_flags_pkg;
	typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
	typedef enum logic [1:0] {TX_DATA, TX_PREAMBLE, TX_BREAK} tx_kind_t;
endpackage

// file: src/serial_tx_shifter.sv
// Transmit shifter: sends one data, preamble or break frame, 16 sample ticks per bit.
// Assumes tick is a one-cycle pulse at sixteen times the bit rate.
`timescale 1ns/1ps
`default_nettype none
`include "serial_flags_params.svh"
module serial_tx_shifter (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic tick,
	input wire logic start,
	input wire serial_flags_pkg::tx_kind_t kind,
	input wire logic [7:0] data,
	input wire logic nine_bit,
	input wire logic parity_en,
	input wire logic parity_odd,
	output logic ready,
	output logic txd
);
	logic [10:0] frame_q;
	logic [10:0] load;
	logic [3:0] tick_q, bit_q, len_q;
	logic busy_q;
	wire [3:0] frame_len = nine_bit ? `TX_BITS_9 : `TX_BITS_8;
	wire par8 = ^data[6:0] ^ parity_odd;
	wire par9 = ^data ^ parity_odd;
	wire b7 = (parity_en && !nine_bit) ? par8 : data[7];
	// In eight-bit frames this slot is the stop bit: held high and shifted out last
	wire b8 = !nine_bit || !parity_en || par9;
	wire [10:0] data_frame = {1'b1, b8, b7, data[6:0], 1'b0};
	wire bit_end = busy_q && tick && tick_q == `LAST_TICK;
	wire last_bit = bit_q == len_q - 4'h1;

	assign ready = !busy_q;

	always_comb begin
		unique case (kind)
			serial_flags_pkg::TX_DATA: load = data_frame;
			serial_flags_pkg::TX_PREAMBLE: load = '1;
			serial_flags_pkg::TX_BREAK: load = '0;
			default: load = '1;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			busy_q <= 1'b0;
			len_q <= `TX_BITS_8;
		end else if (start && !busy_q) begin
			busy_q <= 1'b1;
			len_q <= frame_len;
		end else if (bit_end && last_bit) begin
			busy_q <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			frame_q <= '1;
			txd <= 1'b1;
		end else if (start && !busy_q) begin
			frame_q <= load;
			txd <= load[0];
		end else if (bit_end) begin
			frame_q <= {1'b1, frame_q[10:1]};
			txd <= last_bit ? 1'b1 : frame_q[1];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n || (start && !busy_q)) begin
			tick_q <= 4'h0;
			bit_q <= 4'h0;
		end else if (busy_q && tick) begin
			tick_q <= tick_q + 4'h1;
			if (tick_q == `LAST_TICK)
				bit_q <= bit_q + 4'h1;
		end
	end
endmodule
`default_nettype wire

// file: src/serial_port_status_flags.sv
// Serial port with its first status register, flag clearing sequences and Wishbone slave.
// Assumes a classic Wishbone master on clk_sys and an rxd line already synchronous to it.
// Function
// - Transmit-empty flag set at reset and when buffer moves into the shifter.
// - Transmit-empty clears only after status read showing it, then data write.
// - Transmit-complete set at reset and while empty buffer and nothing shifting.
// - Transmit-complete clears after status read, then data write, enable rise or break.
// - Receive-full flag set when a character enters the receive data register.
// - Receive-full clears after status read showing it, then data register read.
// - Idle flag set after line high one character time: 10 or 11 bits.
// - Idle type zero counts after start bit; one counts after stop bit only.
// - Idle clears by read sequence; sets once until next receive-full set.
// - Overrun set when new character finds previous unread; new character discarded.
// - Overrun clears after status read showing it, then data register read.
// - Seven start samples, three per bit; disagreement sets noise with receive-full.
// - Noise flag clears after status read then data register read.
// - Framing error set with receive-full when stop position samples zero.
// - Framing error clears after status read showing it, then data read.
// - Parity error set with receive-full when enabled parity bit mismatches.
// - Parity error clears after status read then data register read.
// - Status flags are read-only; status writes change nothing.
// - Transmit interrupt requested while transmit-empty set and its enable set.
// - Parity type zero even, one odd, counting all ones with parity.
`timescale 1ns/1ps
`default_nettype none
`include "serial_flags_params.svh"
module serial_port_status_flags #(
	parameter int SAMPLE_DIV = 54
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] adr_i,
	input wire logic [3:0] sel_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic rxd,
	output logic txd,
	output logic tx_irq
);
	localparam int DW = $clog2(SAMPLE_DIV);
	logic [DW-1:0] div_q;
	logic ack_q;
	logic [31:0] dat_q;
	logic [7:0] flags_q, arm_q, set_v, clr_ev, clr_v, ctrl_q, tx_buf_q, rx_data_q;
	logic buf_full_q, pend_pre_q, pend_brk_q, noise_q, idle_en_q;
	logic tx_ready;
	serial_flags_pkg::rx_state_t state_q, state_d;
	logic [3:0] cnt_q, bits_q, idle_tick_q, idle_bits_q;
	logic [2:0] vote_q;
	logic [8:0] shift_q;

	// Sample tick at sixteen times the bit rate
	wire tick = div_q == DW'(SAMPLE_DIV - 1);

	// Bus decode
	wire acc = cyc_i && stb_i && !ack_q;
	wire hit_st = adr_i == `OFF_STATUS;
	wire hit_dat = adr_i == `OFF_DATA;
	wire hit_ctl = adr_i == `OFF_CTRL;
	wire st_rd = acc && !we_i && hit_st && sel_i[0];
	wire st_wr = acc && we_i && hit_st && sel_i[0];
	wire dat_rd = acc && !we_i && hit_dat && sel_i[0];
	wire dat_wr = acc && we_i && hit_dat && sel_i[0];
	wire ctl_wr = acc && we_i && hit_ctl && sel_i[0];
	wire te_rise = ctl_wr && dat_i[`CT_TE] && !ctrl_q[`CT_TE];
	wire sbk_wr = ctl_wr && dat_i[`CT_SBK];
	wire [7:0] rd_byte = hit_st ? flags_q : hit_dat ? rx_data_q : hit_ctl ? ctrl_q : 8'h00;
	wire m9 = ctrl_q[`CT_M9];

	assign dat_o = dat_q;
	assign ack_o = ack_q;
	assign tx_irq = ctrl_q[`CT_TIE] && flags_q[`ST_TX_BUFFER_EMPTY_FLAG];

	// Transmit side: breaks go first, then a queued preamble, then buffered data
	wire tx_start = ctrl_q[`CT_TE] && tx_ready && (pend_brk_q || pend_pre_q || buf_full_q);
	wire serial_flags_pkg::tx_kind_t tx_kind = pend_brk_q ? serial_flags_pkg::TX_BREAK :
		pend_pre_q ? serial_flags_pkg::TX_PREAMBLE : serial_flags_pkg::TX_DATA;
	wire tx_xfer = tx_start && tx_kind == serial_flags_pkg::TX_DATA;
	// A start event in this cycle makes the transmitter busy, so it must not re-set the flag
	wire tc_set = flags_q[`ST_TX_BUFFER_EMPTY_FLAG] && tx_ready && !buf_full_q && !pend_pre_q && !pend_brk_q &&
		!dat_wr && !te_rise && !sbk_wr;

	serial_tx_shifter tx_u (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.tick(tick),
		.start(tx_start),
		.kind(tx_kind),
		.data(tx_buf_q),
		.nine_bit(m9),
		.parity_en(ctrl_q[`CT_PE]),
		.parity_odd(ctrl_q[`CT_PT]),
		.ready(tx_ready),
		.txd(txd)
	);

	// Receive sampling and voting
	wire rx_busy = state_q != serial_flags_pkg::RX_IDLE;
	wire is_start = state_q == serial_flags_pkg::RX_START;
	wire in_win = (cnt_q >= (is_start ? `START_WIN_LO : `BIT_WIN_LO)) && cnt_q <= `BIT_DECIDE;
	wire [2:0] ones = vote_q + {2'b00, rxd};
	wire decide = tick && rx_busy && cnt_q == `BIT_DECIDE;
	wire bit_val = ones >= (is_start ? `START_MAJ : `BIT_MAJ);
	wire noisy = ones != 3'h0 && (is_start || ones != `BIT_ALL);
	wire bit_last = tick && cnt_q == `LAST_TICK;
	wire last_data = bits_q == (m9 ? `DATA_LAST_9 : `DATA_LAST_8);
	wire xfer = decide && state_q == serial_flags_pkg::RX_STOP;
	wire [7:0] rx_byte = m9 ? shift_q[7:0] : shift_q[8:1];
	wire par = m9 ? ^shift_q : ^shift_q[8:1];
	wire par_err = ctrl_q[`CT_PE] && (par != ctrl_q[`CT_PT]);
	// A clear in the same cycle frees the register, so the new character is kept
	wire rx_buffer_full_flag_busy = flags_q[`ST_RX_BUFFER_FULL_FLAG] && !clr_v[`ST_RX_BUFFER_FULL_FLAG];
	wire load_ev = xfer && !rx_buffer_full_flag_busy;
	wire overrun_ev = xfer && rx_buffer_full_flag_busy;

	// Idle line counting
	wire data_or_stop = state_q == serial_flags_pkg::RX_DATA || state_q == serial_flags_pkg::RX_STOP;
	wire idle_cnt_en = rxd && (!rx_busy || (!ctrl_q[`CT_ILT] && data_or_stop));
	wire [3:0] idle_need = m9 ? `IDLE_BITS_9 : `IDLE_BITS_8;
	wire idle_full = idle_bits_q == idle_need;
	wire idle_ev = idle_en_q && idle_full;

	always_comb begin
		set_v = 8'h00;
		set_v[`ST_TX_BUFFER_EMPTY_FLAG] = tx_xfer;
		set_v[`ST_TC] = tc_set;
		set_v[`ST_RX_BUFFER_FULL_FLAG] = load_ev;
		set_v[`ST_IDLE] = idle_ev;
		set_v[`ST_OR] = overrun_ev;
		set_v[`ST_NF] = load_ev && (noise_q || noisy);
		set_v[`ST_FE] = load_ev && !bit_val;
		set_v[`ST_PF] = load_ev && par_err;
	end

	always_comb begin
		clr_ev = {8{dat_rd}} & `RX_FLAG_MASK;
		clr_ev[`ST_TX_BUFFER_EMPTY_FLAG] = dat_wr;
		clr_ev[`ST_TC] = dat_wr || te_rise || sbk_wr;
	end
	assign clr_v = arm_q & clr_ev;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			serial_flags_pkg::RX_IDLE: begin
				if (tick && !rxd)
					state_d = serial_flags_pkg::RX_START;
			end
			serial_flags_pkg::RX_START: begin
				if (decide && bit_val)
					state_d = serial_flags_pkg::RX_IDLE;
				else if (bit_last)
					state_d = serial_flags_pkg::RX_DATA;
			end
			serial_flags_pkg::RX_DATA: begin
				if (bit_last && last_data)
					state_d = serial_flags_pkg::RX_STOP;
			end
			serial_flags_pkg::RX_STOP: begin
				if (decide)
					state_d = serial_flags_pkg::RX_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n || tick)
			div_q <= '0;
		else
			div_q <= div_q + DW'(1);
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
			ctrl_q <= `CTRL_RST;
		end else begin
			ack_q <= acc;
			if (acc && !we_i)
				dat_q <= {24'h00_0000, rd_byte};
			if (ctl_wr)
				ctrl_q <= dat_i[7:0] & `CTRL_MASK;
		end
	end

	// Status writes reach neither flags nor arms
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			flags_q <= `STATUS_RST;
			arm_q <= 8'h00;
		end else begin
			flags_q <= (flags_q & ~clr_v) | set_v;
			arm_q <= st_rd ? flags_q : (arm_q & ~clr_v);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			buf_full_q <= 1'b0;
			pend_pre_q <= 1'b0;
			pend_brk_q <= 1'b0;
		end else begin
			buf_full_q <= dat_wr || (buf_full_q && !tx_xfer);
			pend_pre_q <= te_rise || (pend_pre_q && !(tx_start && tx_kind == serial_flags_pkg::TX_PREAMBLE));
			pend_brk_q <= sbk_wr || (pend_brk_q && !(tx_start && tx_kind == serial_flags_pkg::TX_BREAK));
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			tx_buf_q <= 8'h00;
		else if (dat_wr)
			tx_buf_q <= dat_i[7:0];
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_q <= serial_flags_pkg::RX_IDLE;
			cnt_q <= 4'h0;
			vote_q <= 3'h0;
		end else begin
			state_q <= state_d;
			cnt_q <= !rx_busy ? 4'h0 : tick ? cnt_q + 4'h1 : cnt_q;
			if (!rx_busy || decide || bit_last)
				vote_q <= 3'h0;
			else if (tick && in_win)
				vote_q <= ones;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n || state_q != serial_flags_pkg::RX_DATA)
			bits_q <= 4'h0;
		else if (bit_last)
			bits_q <= bits_q + 4'h1;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			shift_q <= 9'h000;
			noise_q <= 1'b0;
			rx_data_q <= 8'h00;
		end else begin
			if (decide && state_q == serial_flags_pkg::RX_DATA)
				shift_q <= {bit_val, shift_q[8:1]};
			if (!rx_busy)
				noise_q <= 1'b0;
			else if (decide && noisy && !(is_start && bit_val))
				noise_q <= 1'b1;
			if (load_ev)
				rx_data_q <= rx_byte;
		end
	end

	// Any low sample restarts the count, so a glitch cannot fake an idle line
	always_ff @(posedge clk_sys) begin
		if (!rst_n || !idle_cnt_en)
			{idle_bits_q, idle_tick_q} <= 8'h00;
		else if (tick && !idle_full)
			{idle_bits_q, idle_tick_q} <= {idle_bits_q, idle_tick_q} + 8'h01;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			idle_en_q <= 1'b0;
		else if (load_ev)
			idle_en_q <= 1'b1;
		else if (idle_ev)
			idle_en_q <= 1'b0;
	end

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	sequence s_tx_buffer_empty_flag_write;
		dat_wr && arm_q[`ST_TX_BUFFER_EMPTY_FLAG] && !tx_xfer;
	endsequence
	sequence s_tx_quiet;
		flags_q[`ST_TX_BUFFER_EMPTY_FLAG] && tx_ready && !buf_full_q && !pend_pre_q && !pend_brk_q;
	endsequence
	sequence s_idle_hit;
		idle_ev ##1 flags_q[`ST_IDLE];
	endsequence

	AST_EMPTY_OUT_OF_RESET: assert property ($rose(rst_n) |-> flags_q[`ST_TX_BUFFER_EMPTY_FLAG] && flags_q[`ST_TC])
		else $error("transmit flags not set after reset");
	AST_TX_BUFFER_EMPTY_FLAG_ON_TRANSFER: assert property (tx_xfer |=> flags_q[`ST_TX_BUFFER_EMPTY_FLAG] && !tx_ready && !buf_full_q)
		else $error("buffer transfer did not set transmit-empty");
	AST_TX_BUFFER_EMPTY_FLAG_CLEAR: assert property (s_tx_buffer_empty_flag_write |=> !flags_q[`ST_TX_BUFFER_EMPTY_FLAG] && buf_full_q)
		else $error("armed data write did not clear transmit-empty");
	AST_TX_BUFFER_EMPTY_FLAG_ONLY_BY_SEQ: assert property ($fell(flags_q[`ST_TX_BUFFER_EMPTY_FLAG]) |-> $past(dat_wr && arm_q[`ST_TX_BUFFER_EMPTY_FLAG]))
		else $error("transmit-empty cleared without its sequence");
	AST_TC_IDLE: assert property (s_tx_quiet ##1 s_tx_quiet |-> flags_q[`ST_TC])
		else $error("transmit-complete low while transmitter idle");
	AST_TC_CLEAR: assert property ($fell(flags_q[`ST_TC]) |-> $past(arm_q[`ST_TC] && (dat_wr || te_rise || sbk_wr)))
		else $error("transmit-complete cleared without its sequence");
	AST_RX_BUFFER_FULL_FLAG_LOAD: assert property (load_ev |=> flags_q[`ST_RX_BUFFER_FULL_FLAG] && rx_data_q == $past(rx_byte))
		else $error("received character not loaded with receive-full");
	AST_RX_BUFFER_FULL_FLAG_KEPT: assert property (dat_rd && !arm_q[`ST_RX_BUFFER_FULL_FLAG] && flags_q[`ST_RX_BUFFER_FULL_FLAG] |=> flags_q[`ST_RX_BUFFER_FULL_FLAG])
		else $error("unarmed receive-full was cleared");
	AST_IDLE_ONCE: assert property (s_idle_hit |-> !idle_en_q ##1 !idle_ev)
		else $error("idle flag may set twice in one idle period");
	AST_ILT_AFTER_STOP: assert property (ctrl_q[`CT_ILT] && rx_busy ##1 ctrl_q[`CT_ILT] && rx_busy |-> idle_bits_q == 4'h0)
		else $error("idle count ran inside a character with idle type one");
	AST_OVERRUN_DISCARD: assert property (overrun_ev |=> flags_q[`ST_OR] && $stable(rx_data_q) && $stable(flags_q[`ST_FE]))
		else $error("overrun did not discard the new character");
	AST_NOISE_WITH_RX_BUFFER_FULL_FLAG: assert property (xfer && !rx_buffer_full_flag_busy && noisy |=> flags_q[`ST_NF] && flags_q[`ST_RX_BUFFER_FULL_FLAG])
		else $error("noisy stop bit not flagged");
	AST_FE_WITH_RX_BUFFER_FULL_FLAG: assert property ($rose(flags_q[`ST_FE]) |-> $rose(flags_q[`ST_RX_BUFFER_FULL_FLAG]) || $past(load_ev && !bit_val))
		else $error("framing error set without a frame end");
	AST_PARITY: assert property (load_ev && ctrl_q[`CT_PE] && (par != ctrl_q[`CT_PT]) |=> flags_q[`ST_PF])
		else $error("parity mismatch not flagged");
	AST_STATUS_WRITE: assert property (st_wr && set_v == 8'h00 |=> flags_q == $past(flags_q) && arm_q == $past(arm_q))
		else $error("status write changed a flag");
	AST_TX_IRQ: assert property (flags_q[`ST_TX_BUFFER_EMPTY_FLAG] && ctrl_q[`CT_TIE] |-> tx_irq)
		else $error("transmit interrupt missing");
endmodule
`default_nettype wire

// file: tb/serial_far_end.sv
// Far-end serial transceiver: drives frames onto the receive line and decodes the transmit line.
// Assumes 8-bit frames, LSB first, and a bit time of BIT_CLKS cycles of clk_sys.
`timescale 1ns/1ps
`default_nettype none
module serial_far_end #(
	parameter int BIT_CLKS = 32
) (
	input wire logic clk_sys,
	input wire logic line_in,
	output logic line_out,
	output logic [7:0] got_byte,
	output int got_count
);
	logic [7:0] shift;
	initial begin
		line_out = 1'b1;
		got_byte = 8'h00;
		got_count = 0;
	end
	// Frame bits go out start first; bit 9 is the stop position, zero only for a framing fault
	task automatic send(input logic [9:0] frame, input int glitch);
		for (int i = 0; i < 10; i++) begin
			for (int c = 0; c < BIT_CLKS; c++) begin
				@(posedge clk_sys);
				// One tick wide, so exactly one of the three mid-bit samples disagrees
				line_out <= frame[i] ^ (i == glitch && c >= BIT_CLKS / 2 && c < BIT_CLKS / 2 + 2);
			end
		end
		@(posedge clk_sys);
		line_out <= 1'b1;
	endtask
	// Waits for a high line first, so a long break is decoded only once
	always begin
		wait (line_in === 1'b1);
		@(negedge line_in);
		repeat (BIT_CLKS / 2) @(posedge clk_sys);
		for (int i = 0; i < 8; i++) begin
			repeat (BIT_CLKS) @(posedge clk_sys);
			shift[i] = line_in;
		end
		got_byte <= shift;
		got_count <= got_count + 1;
	end
endmodule
`default_nettype wire

// file: tb/serial_port_status_flags_bench.sv
// Self-checking bench for the serial status flags over classic Wishbone.
// Assumes the far-end model in serial_far_end.sv and SAMPLE_DIV shortened to 2.
`timescale 1ns/1ps
`default_nettype none
module serial_port_status_flags_bench;
	localparam int SDIV = 2;
	localparam int BIT = 16 * SDIV;
	logic clk_sys, rst_n, cyc, stb, we, ack_o, rxd, txd, tx_irq;
	logic [3:0] adr;
	logic [31:0] wdat, dat_o;
	logic [7:0] got_byte, r;
	int got_count, bad_count, checks_done;
	serial_port_status_flags #(.SAMPLE_DIV(SDIV)) dut_u (.clk_sys(clk_sys), .rst_n(rst_n),
		.cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(wdat),
		.dat_o(dat_o), .ack_o(ack_o), .rxd(rxd), .txd(txd), .tx_irq(tx_irq));
	serial_far_end #(.BIT_CLKS(BIT)) far_u (.clk_sys(clk_sys), .line_in(txd), .line_out(rxd),
		.got_byte(got_byte), .got_count(got_count));
	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		checks_done++;
		if (seen !== want) begin
			bad_count++;
			$display("BAD t=%0t seen %h want %h", $time, seen, want);
		end
	endtask
	// Holds the request until ack is sampled, then leaves one idle cycle
	task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= {24'h000000, d};
		do begin
			@(posedge clk_sys);
			n++;
		end while (ack_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			bad_count++;
			$display("BAD t=%0t no ack", $time);
		end
		r = dat_o[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_sys);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] want);
		wb(1'b0, a, 8'h00);
		check(r, want);
	endtask
	task automatic bits(input int n);
		repeat (n * BIT) @(posedge clk_sys);
	endtask
	task automatic tx_wait(input int n, input logic [7:0] want);
		int k;
		k = 0;
		while (got_count < n && k < 20 * BIT) begin
			@(posedge clk_sys);
			k++;
		end
		check(got_byte, want);
	endtask
	// Frame, then a full idle spell, then status, data and the cleared status
	task automatic rx_case(input logic [7:0] d, input logic stp, input int g, input logic [7:0] st);
		far_u.send({stp, d, 1'b0}, g);
		bits(12);
		rd(4'h0, st);
		rd(4'h4, d);
		rd(4'h0, 8'hc0);
	endtask
	initial begin
		repeat (40000) @(posedge clk_sys);
		bad_count++;
		close_out();
	end
	initial begin
		rst_n = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 4'h0;
		wdat = 32'h00000000;
		bad_count = 0;
		checks_done = 0;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		rd(4'h0, 8'hc0);
		check({7'h00, tx_irq}, 8'h00);
		wb(1'b1, 4'h0, 8'hff);
		rd(4'h0, 8'hc0);
		rd(4'hc, 8'h00);
		wb(1'b1, 4'h8, 8'he0);
		rd(4'h8, 8'ha0);
		check({7'h00, tx_irq}, 8'h01);
		// The enable rise queued a preamble; let it finish before the status is expected idle
		bits(12);
		$display("registers done");
		rd(4'h0, 8'hc0);
		wb(1'b1, 4'h4, 8'h5a);
		rd(4'h0, 8'h80);
		wb(1'b1, 4'h4, 8'ha5);
		rd(4'h0, 8'h00);
		check({7'h00, tx_irq}, 8'h00);
		tx_wait(1, 8'h5a);
		tx_wait(2, 8'ha5);
		bits(2);
		rd(4'h0, 8'hc0);
		wb(1'b1, 4'h8, 8'hb0);
		rd(4'h0, 8'h80);
		tx_wait(3, 8'h00);
		bits(4);
		rd(4'h0, 8'hc0);
		wb(1'b1, 4'h8, 8'h80);
		wb(1'b1, 4'h8, 8'ha0);
		rd(4'h0, 8'h80);
		bits(12);
		rd(4'h0, 8'hc0);
		$display("transmit done");
		rx_case(8'h3c, 1'b1, -1, 8'hf0);
		bits(12);
		rd(4'h0, 8'hc0);
		rx_case(8'h3c, 1'b1, 3, 8'hf4);
		rx_case(8'h3c, 1'b0, -1, 8'hf2);
		wb(1'b1, 4'h8, 8'ha2);
		rx_case(8'h01, 1'b1, -1, 8'hf1);
		rx_case(8'h81, 1'b1, -1, 8'hf0);
		wb(1'b1, 4'h8, 8'ha3);
		rx_case(8'h01, 1'b1, -1, 8'hf0);
		wb(1'b1, 4'h8, 8'ha0);
		far_u.send({1'b1, 8'h11, 1'b0}, -1);
		far_u.send({1'b1, 8'h22, 1'b0}, -1);
		bits(12);
		rd(4'h0, 8'hf8);
		rd(4'h4, 8'h11);
		rd(4'h0, 8'hc0);
		far_u.send({1'b1, 8'h55, 1'b0}, -1);
		bits(12);
		rd(4'h4, 8'h55);
		rd(4'h0, 8'hf0);
		rd(4'h4, 8'h55);
		rd(4'h0, 8'hc0);
		$display("receive done");
		for (int t = 0; t < 2; t++) begin
			wb(1'b1, 4'h8, t == 0 ? 8'ha0 : 8'ha4);
			far_u.send({1'b1, 8'hff, 1'b0}, -1);
			bits(3);
			rd(4'h0, t == 0 ? 8'hf0 : 8'he0);
			bits(12);
			rd(4'h0, 8'hf0);
			rd(4'h4, 8'hff);
			rd(4'h0, 8'hc0);
		end
		$display("idle type done");
		close_out();
	end
endmodule
`default_nettype wire
